// File: include/irtsc_pkg.sv
// constants for the infrared timer shared control block
package irtsc_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_BYTE_CTRL  = 6'h00;
	localparam logic [5:0] IDX_SHARED     = 6'h01;
	localparam logic [5:0] IDX_LEVEL_LO   = 6'h04;
	localparam logic [5:0] IDX_LEVEL_HI   = 6'h05;
	localparam int         ADDR_W         = 8;

	// byte_timer_control fields
	localparam int BC_ENABLE   = 7;
	localparam int BC_SINGLE   = 6;
	localparam int BC_TIMEOUT  = 5;
	localparam int BC_CLK_HI   = 4;
	localparam int BC_CLK_LO   = 3;
	localparam int BC_CAP_MASK = 2;
	localparam int BC_TO_MASK  = 1;
	localparam int BC_PIN_SEL  = 0;

	// timer_shared_control fields
	localparam int SH_MODE     = 7;
	localparam int SH_OUT_IN   = 6;
	localparam int SH_COMB_HI  = 5;
	localparam int SH_COMB_LO  = 4;
	localparam int SH_SUB_HI   = 3;
	localparam int SH_SUB_LO   = 2;
	localparam int SH_BYTE_INI = 1;
	localparam int SH_WORD_INI = 0;

	// values after power-on reset
	localparam logic [1:0] RST_CLK_SEL  = 2'h0;
	localparam logic [1:0] RST_COMB_SEL = 2'h0;
	localparam logic [1:0] RST_SUBMODE  = 2'h0;
	localparam logic [7:0] RST_LEVEL    = 8'h00;

	// combine / edge / submode encodings
	localparam logic [1:0] COMB_AND  = 2'h0;
	localparam logic [1:0] COMB_OR   = 2'h1;
	localparam logic [1:0] COMB_NOR  = 2'h2;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	localparam logic [1:0] SUB_NORMAL   = 2'h0;
	localparam logic [1:0] SUB_PINGPONG = 2'h1;
	localparam logic [1:0] SUB_FORCE0   = 2'h2;
	localparam logic [1:0] SUB_FORCE1   = 2'h3;

	// glitch filter widths in system clock cycles
	localparam logic [3:0] FILT_NONE_CYC  = 4'h1;
	localparam logic [3:0] FILT_SHORT_CYC = 4'h4;
	localparam logic [3:0] FILT_LONG_CYC  = 4'h8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irtsc_pkg

// File: hdl/irtsc_top.sv
// infrared byte timer and shared timer control with axi4-lite register access
// Operation
// - writing 1 to the enable field starts the byte timer counting
// - pass-select 0 reloads at terminal count, 1 stops at terminal count
// - timeout flag set at terminal count, cleared only by writing 1
// - first counting clock after enable may be short and arrive anytime
// - clock field selects system clock divided by 1, 2, 4 or 8
// - demodulation capture edge requests interrupt when capture mask set
// - timeout requests interrupt when timeout mask set
// - output-select routes port output or byte timer output to its pin
// - shared bit 7 selects transmit (0) or demodulation (1) mode
// - bit 6 selects combined output pin source or demodulator input pin
// - transmit bits 5:4 combine timer outputs by AND, OR, NOR, NAND
// - demodulation bits 5:4 select falling, rising or both edges
// - transmit bits 3:2 normal, ping-pong, force word output 0 or 1
// - demodulation bits 3:2 select glitch filter none, 4 or 8 clocks
// - bit 1 sets byte output start level, opposite held while disabled
// - bit 0 sets word output start level, only in normal or ping-pong
// - demodulation bit 1 flags rising edge, write 1 clears
// - demodulation bit 0 flags falling edge, write 1 clears
// - double-asterisk fields reset at power-on only, kept through stop recovery
//
// Our own choice: the AXI4-Lite register port.
module irtsc_top (
	// clock and resets
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        stop_rec_rst_i,
	// axi4-lite write address and data
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// word timer datapath
	input  wire logic        word_timer_enabled_i,
	input  wire logic        word_timer_level_i,
	// port pins
	input  wire logic        byte_timer_port_i,
	input  wire logic        combined_port_i,
	input  wire logic        first_input_pin_i,
	input  wire logic        second_input_pin_i,
	output logic             byte_timer_pin_o,
	output logic             combined_output_pin_o,
	// events
	output logic             capture_edge_o,
	output logic             capture_irq_o,
	output logic             timeout_irq_o
);

	function automatic logic [2:0] reg_sel(input logic [7:0] addr);
		logic [5:0] idx;
		idx = addr[7:2];
		case (idx)
			irtsc_pkg::IDX_BYTE_CTRL: reg_sel = 3'h1;
			irtsc_pkg::IDX_SHARED:    reg_sel = 3'h2;
			irtsc_pkg::IDX_LEVEL_LO:  reg_sel = 3'h3;
			irtsc_pkg::IDX_LEVEL_HI:  reg_sel = 3'h4;
			default:                  reg_sel = 3'h0;
		endcase
	endfunction : reg_sel

	////////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	logic        aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic [7:0]  awaddr_q;
	logic [7:0]  wdata_q;
	logic        wstrb_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic        wr_go;
	logic [2:0]  wr_sel;
	logic        wr_ctrl, wr_shared, wr_lo, wr_hi;
	logic [7:0]  rd_byte;
	assign s_axi_awready_o = !aw_full_q && !bvalid_q;
	assign s_axi_wready_o  = !w_full_q && !bvalid_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;
	assign s_axi_arready_o = !rvalid_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;

	assign wr_go     = aw_full_q && w_full_q && !bvalid_q;
	assign wr_sel    = reg_sel(awaddr_q);
	// upper byte lanes hold nothing, so only lane 0 matters
	assign wr_ctrl   = wr_go && wstrb_q && (wr_sel == 3'h1);
	assign wr_shared = wr_go && wstrb_q && (wr_sel == 3'h2);
	assign wr_lo     = wr_go && wstrb_q && (wr_sel == 3'h3);
	assign wr_hi     = wr_go && wstrb_q && (wr_sel == 3'h4);

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			aw_full_q <= 1'b0;
			awaddr_q  <= 8'h00;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_full_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr_i;
		end else if (wr_go) begin
			aw_full_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			w_full_q <= 1'b0;
			wdata_q  <= 8'h00;
			wstrb_q  <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_full_q <= 1'b1;
			wdata_q  <= s_axi_wdata_i[7:0];
			wstrb_q  <= s_axi_wstrb_i[0];
		end else if (wr_go) begin
			w_full_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			bvalid_q <= 1'b0;
			bresp_q  <= irtsc_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_sel == 3'h0) ? irtsc_pkg::RESP_SLVERR : irtsc_pkg::RESP_OKAY;
		end else if (s_axi_bready_i) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= irtsc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rd_byte};
			rresp_q  <= (reg_sel(s_axi_araddr_i) == 3'h0) ? irtsc_pkg::RESP_SLVERR : irtsc_pkg::RESP_OKAY;
		end else if (s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control fields
	logic       single_q, timeout_q, cap_mask_q, to_mask_q, pin_sel_q;
	logic [1:0] clk_sel_q;
	logic       mode_q, out_in_q, byte_ini_q, word_ini_q, rise_q, fall_q;
	logic [1:0] comb_sel_q, sub_q;
	logic [7:0] level_lo_q, level_hi_q;
	logic       en_q, out_q;
	logic [7:0] cnt_q;
	logic       term_ev, rise_det, fall_det;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			single_q   <= 1'b0;
			pin_sel_q  <= 1'b0;
			clk_sel_q  <= irtsc_pkg::RST_CLK_SEL;
			cap_mask_q <= 1'b0;
			to_mask_q  <= 1'b0;
		end else if (stop_rec_rst_i) begin
			single_q  <= 1'b0;
			pin_sel_q <= 1'b0;
		end else if (wr_ctrl) begin
			single_q   <= wdata_q[irtsc_pkg::BC_SINGLE];
			clk_sel_q  <= wdata_q[irtsc_pkg::BC_CLK_HI:irtsc_pkg::BC_CLK_LO];
			cap_mask_q <= wdata_q[irtsc_pkg::BC_CAP_MASK];
			to_mask_q  <= wdata_q[irtsc_pkg::BC_TO_MASK];
			pin_sel_q  <= wdata_q[irtsc_pkg::BC_PIN_SEL];
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			timeout_q <= 1'b0;
		end else if (term_ev) begin
			timeout_q <= 1'b1;
		end else if (wr_ctrl && wdata_q[irtsc_pkg::BC_TIMEOUT]) begin
			timeout_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mode_q     <= 1'b0;
			out_in_q   <= 1'b0;
			comb_sel_q <= irtsc_pkg::RST_COMB_SEL;
			sub_q      <= irtsc_pkg::RST_SUBMODE;
			byte_ini_q <= 1'b0;
			word_ini_q <= 1'b0;
		end else if (stop_rec_rst_i) begin
			mode_q   <= 1'b0;
			out_in_q <= 1'b0;
		end else if (wr_shared) begin
			mode_q     <= wdata_q[irtsc_pkg::SH_MODE];
			out_in_q   <= wdata_q[irtsc_pkg::SH_OUT_IN];
			comb_sel_q <= wdata_q[irtsc_pkg::SH_COMB_HI:irtsc_pkg::SH_COMB_LO];
			sub_q      <= wdata_q[irtsc_pkg::SH_SUB_HI:irtsc_pkg::SH_SUB_LO];
			// in demodulation these bits are flags, the start levels stay put
			if (!mode_q) begin
				byte_ini_q <= wdata_q[irtsc_pkg::SH_BYTE_INI];
				word_ini_q <= wdata_q[irtsc_pkg::SH_WORD_INI];
			end
		end
	end

	// edge flags: a set wins over a write-one clear in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			rise_q <= rise_det || (rise_q && !(wr_shared && mode_q && wdata_q[irtsc_pkg::SH_BYTE_INI]));
			fall_q <= fall_det || (fall_q && !(wr_shared && mode_q && wdata_q[irtsc_pkg::SH_WORD_INI]));
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			level_lo_q <= irtsc_pkg::RST_LEVEL;
			level_hi_q <= irtsc_pkg::RST_LEVEL;
		end else begin
			if (wr_lo) begin
				level_lo_q <= wdata_q;
			end
			if (wr_hi) begin
				level_hi_q <= wdata_q;
			end
		end
	end

	always_comb begin
		case (reg_sel(s_axi_araddr_i))
			3'h1: rd_byte = {en_q, single_q, timeout_q, clk_sel_q, cap_mask_q, to_mask_q, pin_sel_q};
			3'h2: rd_byte = {mode_q, out_in_q, comb_sel_q, sub_q,
			                 mode_q ? {rise_q, fall_q} : {byte_ini_q, word_ini_q}};
			3'h3: rd_byte = level_lo_q;
			3'h4: rd_byte = level_hi_q;
			default: rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// byte timer
	logic [2:0] pre_q;
	logic [2:0] pre_mask;
	logic       tick;
	logic       start_wr, stop_wr;
	// free-running divider: the first tick after enable lands anywhere
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pre_q <= 3'h0;
		end else begin
			pre_q <= pre_q + 3'h1;
		end
	end

	always_comb begin
		case (clk_sel_q)
			2'h0:    pre_mask = 3'h0;
			2'h1:    pre_mask = 3'h1;
			2'h2:    pre_mask = 3'h3;
			default: pre_mask = 3'h7;
		endcase
	end

	assign tick     = (pre_q & pre_mask) == pre_mask;
	assign start_wr = wr_ctrl && wdata_q[irtsc_pkg::BC_ENABLE];
	assign stop_wr  = wr_ctrl && !wdata_q[irtsc_pkg::BC_ENABLE];
	assign term_ev  = en_q && tick && (cnt_q == 8'h00) && !stop_wr && !stop_rec_rst_i;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || stop_rec_rst_i) begin
			en_q  <= 1'b0;
			cnt_q <= 8'h00;
			out_q <= 1'b0;
		end else if (start_wr && !en_q) begin
			en_q  <= 1'b1;
			out_q <= byte_ini_q;
			cnt_q <= byte_ini_q ? level_hi_q : level_lo_q;
		end else if (stop_wr) begin
			en_q <= 1'b0;
		end else if (term_ev) begin
			out_q <= !out_q;
			if (single_q) begin
				en_q <= 1'b0;
			end else begin
				cnt_q <= out_q ? level_lo_q : level_hi_q;
			end
		end else if (en_q && tick) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit outputs
	logic byte_out, word_out, comb_out;
	assign byte_out = en_q ? out_q : !byte_ini_q;
	always_comb begin
		case (sub_q)
			irtsc_pkg::SUB_FORCE0: word_out = 1'b0;
			irtsc_pkg::SUB_FORCE1: word_out = 1'b1;
			default: word_out = word_timer_enabled_i ? word_timer_level_i : !word_ini_q;
		endcase
	end

	always_comb begin
		case (comb_sel_q)
			irtsc_pkg::COMB_AND: comb_out = byte_out & word_out;
			irtsc_pkg::COMB_OR:  comb_out = byte_out | word_out;
			irtsc_pkg::COMB_NOR: comb_out = !(byte_out | word_out);
			default:             comb_out = !(byte_out & word_out);
		endcase
	end

	assign byte_timer_pin_o      = pin_sel_q ? byte_out : byte_timer_port_i;
	assign combined_output_pin_o = (!mode_q && out_in_q) ? comb_out : combined_port_i;

	////////////////////////////////////////////////////////////////////////
	// demodulator input: sync, glitch filter, edge detect
	logic       sy1_q, sy2_q, sy3_q;
	logic       filt_q;
	logic [3:0] fcnt_q;
	logic [3:0] filt_len;
	logic       filt_upd, edge_sel;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sy1_q <= 1'b0;
			sy2_q <= 1'b0;
			sy3_q <= 1'b0;
		end else begin
			sy1_q <= out_in_q ? second_input_pin_i : first_input_pin_i;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	always_comb begin
		case (sub_q)
			2'h1:    filt_len = irtsc_pkg::FILT_SHORT_CYC;
			2'h2:    filt_len = irtsc_pkg::FILT_LONG_CYC;
			default: filt_len = irtsc_pkg::FILT_NONE_CYC;
		endcase
	end

	// a new level must stay put for the filter length before it counts
	assign filt_upd = (sy2_q == sy3_q) && (sy3_q != filt_q) && ((fcnt_q + 4'h1) >= filt_len);

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			filt_q <= 1'b0;
			fcnt_q <= 4'h0;
		end else if (filt_upd) begin
			filt_q <= sy3_q;
			fcnt_q <= 4'h0;
		end else if ((sy2_q == sy3_q) && (sy3_q != filt_q)) begin
			fcnt_q <= fcnt_q + 4'h1;
		end else begin
			fcnt_q <= 4'h0;
		end
	end

	always_comb begin
		case (comb_sel_q)
			irtsc_pkg::EDGE_FALL: edge_sel = !sy3_q;
			irtsc_pkg::EDGE_RISE: edge_sel = sy3_q;
			irtsc_pkg::EDGE_BOTH: edge_sel = 1'b1;
			default:              edge_sel = 1'b0;
		endcase
	end

	assign rise_det = mode_q && filt_upd && sy3_q && edge_sel;
	assign fall_det = mode_q && filt_upd && !sy3_q && edge_sel;
	assign capture_edge_o = rise_det || fall_det;
	assign capture_irq_o  = cap_mask_q && (rise_det || fall_det);
	assign timeout_irq_o  = to_mask_q && term_ev;

endmodule : irtsc_top

// File: test/irtsc_ir_src.sv
// infrared source model driving the two demodulator pins
module irtsc_ir_src (
	// control from the bench
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic       sel_i,
	input  wire logic [4:0] width_i,
	// pins, idle high
	output logic            first_o,
	output logic            second_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt_q = 5'h00;
	logic       sel_q = 1'b0;
	always_ff @(posedge clk_i) begin
		if (go_i) begin
			cnt_q <= width_i;
			sel_q <= sel_i;
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
		end
	end
	// low pulse on the chosen pin only; the other stays idle
	assign first_o  = !(cnt_q != 5'h00 && !sel_q);
	assign second_o = !(cnt_q != 5'h00 && sel_q);
endmodule : irtsc_ir_src

// File: test/irtsc_top_asserts.sv
// bus and pin checks on the shared timer control block
module irtsc_top_asserts (
	// clock and reset
	input wire logic        ref_clk_i,
	input wire logic        sys_rst_i,
	// bus
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	// pins and events
	input wire logic        byte_timer_port_i,
	input wire logic        combined_port_i,
	input wire logic        byte_timer_pin_o,
	input wire logic        combined_output_pin_o,
	input wire logic        capture_edge_o,
	input wire logic        capture_irq_o,
	input wire logic        timeout_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_bhold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_rhold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	property p_rzero;
		s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000;
	endproperty
	a_rzero: assert property (p_rzero) else $error("upper read bits not zero");
	property p_arrdy;
		s_axi_arready_o == !s_axi_rvalid_o;
	endproperty
	a_arrdy: assert property (p_arrdy) else $error("arready wrong");
	property p_awblk;
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
	endproperty
	a_awblk: assert property (p_awblk) else $error("write accepted while response pending");
	property p_bafter;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o;
	endproperty
	a_bafter: assert property (p_bafter) else $error("write response late");
	property p_rafter;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	a_rafter: assert property (p_rafter) else $error("read response late");
	property p_capirq;
		capture_irq_o |-> capture_edge_o;
	endproperty
	a_capirq: assert property (p_capirq) else $error("capture irq without edge");
	property p_pinrst;
		$fell(sys_rst_i) |-> byte_timer_pin_o == byte_timer_port_i;
	endproperty
	a_pinrst: assert property (p_pinrst) else $error("byte pin not port after reset");
	property p_cmbrst;
		$fell(sys_rst_i) |-> combined_output_pin_o == combined_port_i;
	endproperty
	a_cmbrst: assert property (p_cmbrst) else $error("combined pin not port after reset");
	c_edge: cover property (capture_edge_o);
	c_tout: cover property (timeout_irq_o);
	c_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == irtsc_pkg::RESP_SLVERR);
endmodule : irtsc_top_asserts
bind irtsc_top irtsc_top_asserts chk_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.byte_timer_port_i(byte_timer_port_i), .combined_port_i(combined_port_i),
	.byte_timer_pin_o(byte_timer_pin_o), .combined_output_pin_o(combined_output_pin_o),
	.capture_edge_o(capture_edge_o), .capture_irq_o(capture_irq_o), .timeout_irq_o(timeout_irq_o));

// File: test/test_ir_timer_shared_control.sv
// self-checking bench for the shared timer control block
module test_ir_timer_shared_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, srr = 1'b0, bport = 1'b1, cport = 1'b0;
	logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic        awr, wrd, bv, arr, rv, p1, p2, bpin, cpin, cedge, cirq, tirq;
	logic [1:0]  bresp, rresp;
	logic        go = 1'b0, psel = 1'b0, wen = 1'b0, wlv = 1'b0;
	logic [4:0]  pw = 5'h00;
	int          n_fail = 0, total_checks = 0, n_edge = 0, n_cirq = 0, n_to = 0, cyc = 0, t_now = 0, t_prev = 0;
	localparam logic [1:0] OK = irtsc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = irtsc_pkg::RESP_SLVERR;
	irtsc_top dut_u (.ref_clk_i(clk), .sys_rst_i(rst), .stop_rec_rst_i(srr),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rre), .word_timer_enabled_i(wen), .word_timer_level_i(wlv),
		.byte_timer_port_i(bport), .combined_port_i(cport), .first_input_pin_i(p1),
		.second_input_pin_i(p2), .byte_timer_pin_o(bpin), .combined_output_pin_o(cpin),
		.capture_edge_o(cedge), .capture_irq_o(cirq), .timeout_irq_o(tirq));
	irtsc_ir_src src_u (.clk_i(clk), .go_i(go), .sel_i(psel), .width_i(pw), .first_o(p1), .second_o(p2));
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cedge === 1'b1) n_edge++;
		if (cirq === 1'b1) n_cirq++;
		if (tirq === 1'b1) begin
			t_prev = t_now;
			t_now = cyc;
			n_to++;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wc(input logic [5:0] ix, input logic [7:0] d, input logic [1:0] er = OK);
		@(posedge clk);
		awa <= {ix, 2'b00};
		wd <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge clk);
			if (awr === 1'b1) awv <= 1'b0;
			if (wrd === 1'b1) wv <= 1'b0;
		end while ((awv && awr !== 1'b1) || (wv && wrd !== 1'b1));
		while (bv !== 1'b1) @(posedge clk);
		chk(bresp, er);
		bre <= 1'b0;
	endtask : wc
	task automatic rc(input logic [5:0] ix, input logic [7:0] e, input logic [1:0] er = OK);
		@(posedge clk);
		ara <= {ix, 2'b00};
		arv <= 1'b1;
		rre <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		chk(rd, {24'h000000, e});
		chk(rresp, er);
		rre <= 1'b0;
	endtask : rc
	task automatic wto(input int n);
		for (int k = 0; k < 400 && n_to < n; k++) @(posedge clk);
	endtask : wto
	function automatic logic cmb(input logic [1:0] s, input logic b, input logic w);
		case (s)
			irtsc_pkg::COMB_AND: return b & w;
			irtsc_pkg::COMB_OR:  return b | w;
			irtsc_pkg::COMB_NOR: return !(b | w);
			default:             return !(b & w);
		endcase
	endfunction : cmb
	// one demodulation pass: edge select, filter, pin, pulse width, edges, flags
	task automatic dm(input logic [1:0] e, f, input logic s, input logic [4:0] w, input int c, input logic [1:0] fl);
		int b0, b1;
		wc(1, {1'b1, s, e, f, 2'b11});
		repeat (16) @(posedge clk);
		b0 = n_edge;
		b1 = n_cirq;
		go <= 1'b1;
		psel <= s;
		pw <= w;
		@(posedge clk);
		go <= 1'b0;
		repeat (40) @(posedge clk);
		chk(n_edge - b0, c);
		chk(n_cirq - b1, c);
		rc(1, {1'b1, s, e, f, fl});
	endtask : dm
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rc(0, 8'h00);
		rc(1, 8'h00);
		rc(4, 8'h00);
		rc(5, 8'h00);
		rc(2, 8'h00, ERR);
		wc(2, 8'hff, ERR);
		chk(bpin, 1'b1);
		done("reset");
		// counters stay disabled while start levels change
		for (int i = 0; i < 16; i++) begin
			wc(1, {2'b01, i[1:0], 1'b1, i[2], i[3], 1'b0});
			@(posedge clk);
			#1;
			chk(cpin, cmb(i[1:0], !i[3], i[2]));
		end
		wc(1, 8'h00);
		cport <= 1'b1;
		@(posedge clk);
		#1;
		chk(cpin, 1'b1);
		// normal submode, and: byte side rests high, so the pin shows the word output
		for (int j = 0; j < 8; j++) begin
			wc(1, {7'h20, j[2]});
			wen <= j[0];
			wlv <= j[1];
			#1;
			chk(cpin, j[0] ? j[1] : !j[2]);
		end
		done("combine");
		wc(4, 8'h03);
		wc(5, 8'h03);
		wc(0, 8'h20);
		wc(0, 8'h83);
		wto(3);
		chk(t_now - t_prev, 4);
		wc(0, 8'h03);
		wc(0, 8'h9b);
		wto(n_to + 2);
		chk(t_now - t_prev, 32);
		wc(0, 8'h1b);
		rc(0, 8'h3b);
		wc(0, 8'h1b);
		rc(0, 8'h3b);
		wc(0, 8'h3b);
		rc(0, 8'h1b);
		wc(0, 8'hc3);
		wto(n_to + 1);
		repeat (2) @(posedge clk);
		rc(0, 8'h63);
		chk(bpin, 1'b1);
		done("timer");
		wc(0, 8'h04);
		dm(2'h2, 2'h0, 1'b0, 5'd6, 2, 2'h3);
		dm(2'h0, 2'h1, 1'b0, 5'd6, 1, 2'h1);
		dm(2'h1, 2'h0, 1'b1, 5'd6, 1, 2'h2);
		dm(2'h2, 2'h2, 1'b0, 5'd6, 0, 2'h0);
		dm(2'h2, 2'h2, 1'b0, 5'd12, 2, 2'h3);
		done("demod");
		wc(1, 8'hd7);
		wc(0, 8'h5e);
		rc(0, 8'h7e);
		srr <= 1'b1;
		@(posedge clk);
		srr <= 1'b0;
		rc(0, 8'h3e);
		rc(1, 8'h17);
		done("recovery");
		conclude();
	end
endmodule : test_ir_timer_shared_control
